/* hdl/adcc_clkdiv.sv */
`timescale 1ns/1ps
`include "adcc_map.svh"
// Selects the converter input rate and divides it into a conversion clock enable.
module adcc_clkdiv (
    input  wire logic       i_clk,     // Bus clock.
    input  wire logic       i_arst_n,  // Asynchronous reset, active low.
    input  wire logic [1:0] i_iclk,    // Input clock select.
    input  wire logic [1:0] i_div,     // Clock divide select.
    input  wire logic       i_alt_en,  // Alternate clock enable pulse.
    input  wire logic       i_async_en,// Asynchronous clock enable pulse.
    output logic            o_tick     // Conversion clock enable pulse.
);
    logic       half;
    logic       src;
    logic [2:0] cnt;
    logic [2:0] lim;

    // Source pulse chosen by the input clock select field.
    always_comb begin
        case (i_iclk)
            `ADCC_ICLK_BUS:      src = 1'b1;
            `ADCC_ICLK_BUS_HALF: src = half;
            `ADCC_ICLK_ALT:      src = i_alt_en;
            default:             src = i_async_en;
        endcase
        lim = 3'((4'h1 << i_div) - 4'h1);
    end

    // Bus clock halved for the second source.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) half <= 1'b0;
        else           half <= ~half;
    end

    // Divide the source by 1, 2, 4 or 8.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt    <= 3'h0;
            o_tick <= 1'b0;
        end else begin
            o_tick <= 1'b0;
            if (src) begin
                if (cnt >= lim) begin
                    cnt    <= 3'h0;
                    o_tick <= 1'b1;
                end else begin
                    cnt <= cnt + 3'h1;
                end
            end
        end
    end
endmodule : adcc_clkdiv

/* hdl/adcc_map.svh */
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH
// Input clock select codes.
`define ADCC_ICLK_BUS       2'h0
`define ADCC_ICLK_BUS_HALF  2'h1
`define ADCC_ICLK_ALT       2'h2
`define ADCC_ICLK_ASYNC     2'h3
// Resolution mode codes.
`define ADCC_MODE_8BIT      2'h0
`define ADCC_MODE_10BIT     2'h2
// Channel code that leaves the converter idle.
`define ADCC_CH_IDLE        5'h1f
// Conversion clock counts per conversion phase; the transfer tail counts bus clocks.
`define ADCC_SAMPLE_SHORT   6'h03
`define ADCC_SAMPLE_LONG    6'h17
`define ADCC_FIRST_EXTRA    6'h03
`define ADCC_BUS_TAIL       3'h5
// Asynchronous clock start-up time in ns, and the bus cycles it takes.
`define ADCC_ASYNC_START_NS 5000
`define ADCC_CLK_NS         10
`define ADCC_ASYNC_START_CYC ((`ADCC_ASYNC_START_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)
`endif

/* hdl/adcc_pkg.sv */
package adcc_pkg;
    // Conversion configuration carried as one group.
    typedef struct packed {
        logic [4:0] channel;
        logic       hw_trig;
        logic       cont;
        logic       cmp_en;
        logic       cmp_gte;
        logic [9:0] cmp_val;
        logic [1:0] mode;
        logic       long_smp;
        logic [1:0] iclk;
        logic [1:0] div;
        logic       irq_en;
    } adcc_cfg_s;

    // Conversion sequencer states.
    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_START  = 5'b00010,
        ST_SAMPLE = 5'b00100,
        ST_CONV   = 5'b01000,
        ST_XFER   = 5'b10000
    } adcc_state_e;
endpackage : adcc_pkg

/* hdl/adcc_top.sv */
`timescale 1ns/1ps
`include "adcc_map.svh"
module adcc_top #(
    parameter int PINS = 8,                            // Analog-capable pins.
    parameter int START_CYC = `ADCC_ASYNC_START_CYC    // Asynchronous start-up count.
) (
    input  wire logic               I_CLK,        // Bus clock, 100 MHz.
    input  wire logic               I_ARST_N,     // Asynchronous reset, active low.
    input  wire logic               I_WR_SC1,     // Control register one write strobe.
    input  wire adcc_pkg::adcc_cfg_s I_CFG,       // Configuration; channel taken on write.
    input  wire logic               I_CLR_COCO,   // Clear complete flag pulse.
    input  wire logic               I_HW_TRIG,    // Hardware conversion trigger pin.
    input  wire logic               I_ALT_EN,     // Alternate clock enable pulse.
    input  wire logic               I_ASYNC_EN,   // Asynchronous clock enable pulse.
    input  wire logic               I_CMP_OUT,    // Analog comparator bit decision.
    input  wire logic [PINS-1:0]    I_PIN_DIS,    // Analog pin disable bits.
    input  wire logic [PINS-1:0]    I_PORT_OE,    // Port driver enables.
    input  wire logic [PINS-1:0]    I_PORT_PU,    // Port pullup enables.
    input  wire logic [PINS-1:0]    I_PIN_IN,     // Raw pin levels.
    output logic [PINS-1:0]         O_PIN_OE,     // Gated driver enables.
    output logic [PINS-1:0]         O_PIN_PU,     // Gated pullup enables.
    output logic [PINS-1:0]         O_PORT_RD,    // Pin levels seen by the port.
    output logic [4:0]              O_CHANNEL,    // Channel being converted.
    output logic                    O_TRIAL,      // Trial bit applied to converter.
    output logic [9:0]              O_SAR,        // Approximation register.
    output logic                    O_ACTIVE,     // Conversion in progress.
    output logic [7:0]              O_RESULT_HIGH,// Result high register.
    output logic [7:0]              O_RESULT_LOW, // Result low register.
    output logic                    O_COCO,       // Conversion complete flag.
    output logic                    O_IRQ         // Completion interrupt request.
);
    adcc_pkg::adcc_state_e state;
    adcc_pkg::adcc_cfg_s   cfg;
    logic        tick;
    logic [1:0]  trig_sync;
    logic        trig_q;
    logic        trig_rise;
    logic        first;
    logic        cont_run;
    logic [5:0]  cnt;
    logic [3:0]  bitpos;
    logic [2:0]  tail;
    logic [12:0] start_cnt;
    logic [9:0]  res;
    logic        cmp_hit;
    logic        sw_start;
    logic        hw_start;
    logic [PINS-1:0] pin_sync1;
    logic [PINS-1:0] pin_sync2;

    // Bits of the conversion width are 10 or 8.
    function automatic logic [3:0] top_bit(input logic [1:0] m);
        return (m == `ADCC_MODE_10BIT) ? 4'h9 : 4'h7;
    endfunction : top_bit

    // Start-up wait in bus cycles; only the asynchronous source needs one.
    function automatic logic [12:0] startup_count(input logic [1:0] iclk);
        return (iclk == `ADCC_ICLK_ASYNC) ? 13'(START_CYC) : 13'h0;
    endfunction : startup_count

    adcc_clkdiv u_div (
        .i_clk     (I_CLK),
        .i_arst_n  (I_ARST_N),
        .i_iclk    (cfg.iclk),
        .i_div     (cfg.div),
        .i_alt_en  (I_ALT_EN),
        .i_async_en(I_ASYNC_EN),
        .o_tick    (tick)
    );

    // Pin levels change outside the clock domain, so two flip-flops settle them first.
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pin_sync1 <= '0;
            pin_sync2 <= '0;
        end else begin
            pin_sync1 <= I_PIN_IN;
            pin_sync2 <= pin_sync1;
        end
    end

    // Pin takeover is registered so every output leaves a flip-flop.
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_PIN_OE  <= '0;
            O_PIN_PU  <= '0;
            O_PORT_RD <= '0;
        end else begin
            O_PIN_OE  <= I_PORT_OE & ~I_PIN_DIS;
            O_PIN_PU  <= I_PORT_PU & ~I_PIN_DIS;
            O_PORT_RD <= pin_sync2 & ~I_PIN_DIS;
        end
    end

    // The trigger is asynchronous, so it is synchronised before the edge detector.
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            trig_sync <= 2'h0;
            trig_q    <= 1'b0;
        end else begin
            trig_sync <= {trig_sync[0], I_HW_TRIG};
            trig_q    <= trig_sync[1];
        end
    end

    assign trig_rise = trig_sync[1] & ~trig_q;
    assign sw_start  = I_WR_SC1 & ~I_CFG.hw_trig & (I_CFG.channel != `ADCC_CH_IDLE);
    // Edges while busy or while a continuous run goes on are dropped.
    assign hw_start  = cfg.hw_trig & trig_rise & (state == adcc_pkg::ST_IDLE)
                       & ~cont_run & (cfg.channel != `ADCC_CH_IDLE);

    // Configuration is captured on each control write.
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) cfg <= '{channel: `ADCC_CH_IDLE, default: '0};
        else if (I_WR_SC1) cfg <= I_CFG;
    end

    // Conversion sequencer.
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            state     <= adcc_pkg::ST_IDLE;
            first     <= 1'b1;
            cont_run  <= 1'b0;
            cnt       <= 6'h0;
            bitpos    <= 4'h0;
            tail      <= 3'h0;
            start_cnt <= 13'h0;
            O_SAR     <= 10'h0;
            O_TRIAL   <= 1'b0;
        end else if (I_WR_SC1) begin
            // A write aborts whatever runs and may start anew.
            state     <= sw_start ? adcc_pkg::ST_START : adcc_pkg::ST_IDLE;
            first     <= 1'b1;
            cont_run  <= 1'b0;
            O_TRIAL   <= 1'b0;
            start_cnt <= startup_count(I_CFG.iclk);
        end else begin
            case (state)
                adcc_pkg::ST_IDLE: begin
                    if (hw_start) begin
                        state     <= adcc_pkg::ST_START;
                        first     <= 1'b1;
                        start_cnt <= startup_count(cfg.iclk);
                    end
                end
                adcc_pkg::ST_START: begin
                    // Start-up wait, then first conversions add setup clocks.
                    if (start_cnt != 13'h0) begin
                        start_cnt <= start_cnt - 13'h1;
                    end else begin
                        state <= adcc_pkg::ST_SAMPLE;
                        cnt   <= (cfg.long_smp ? `ADCC_SAMPLE_LONG : `ADCC_SAMPLE_SHORT)
                                 + (first ? `ADCC_FIRST_EXTRA : 6'h0);
                    end
                end
                adcc_pkg::ST_SAMPLE: begin
                    if (tick) begin
                        if (cnt <= 6'h1) begin
                            state   <= adcc_pkg::ST_CONV;
                            bitpos  <= top_bit(cfg.mode);
                            O_SAR   <= 10'h1 << top_bit(cfg.mode);
                            O_TRIAL <= 1'b1;
                        end else begin
                            cnt <= cnt - 6'h1;
                        end
                    end
                end
                adcc_pkg::ST_CONV: begin
                    // One bit decided per conversion clock; the next trial bit rises with it.
                    if (tick) begin
                        O_SAR[bitpos] <= I_CMP_OUT;
                        if (bitpos == 4'h0) begin
                            state   <= adcc_pkg::ST_XFER;
                            O_TRIAL <= 1'b0;
                            tail    <= first ? `ADCC_BUS_TAIL : 3'h1;
                        end else begin
                            bitpos <= bitpos - 4'h1;
                            O_SAR[bitpos - 4'h1] <= 1'b1;
                        end
                    end
                end
                adcc_pkg::ST_XFER: begin
                    if (tail <= 3'h1) begin
                        first <= 1'b0;
                        if (cfg.cont) begin
                            state    <= adcc_pkg::ST_START;
                            cont_run <= 1'b1;
                        end else begin
                            state <= adcc_pkg::ST_IDLE;
                        end
                    end else begin
                        tail <= tail - 3'h1;
                    end
                end
                default: state <= adcc_pkg::ST_IDLE;
            endcase
        end
    end

    // Result is right justified; 8-bit mode keeps the upper bits zero.
    assign res = (cfg.mode == `ADCC_MODE_10BIT) ? O_SAR : {2'h0, O_SAR[7:0]};
    assign cmp_hit = cfg.cmp_gte ? (res >= cfg.cmp_val) : (res < cfg.cmp_val);
    wire xfer_done = (state == adcc_pkg::ST_XFER) && (tail <= 3'h1) && !I_WR_SC1;

    // Results load at completion; with compare on, only matching results land.
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_RESULT_HIGH <= 8'h0;
            O_RESULT_LOW  <= 8'h0;
        end else if (xfer_done && (!cfg.cmp_en || cmp_hit)) begin
            O_RESULT_HIGH <= {6'h0, res[9:8]};
            O_RESULT_LOW  <= res[7:0];
        end
    end

    // Completion flag: a new result beats a simultaneous clear.
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_COCO <= 1'b0;
            O_IRQ  <= 1'b0;
        end else begin
            if (xfer_done && (!cfg.cmp_en || cmp_hit)) O_COCO <= 1'b1;
            else if (I_CLR_COCO || I_WR_SC1)          O_COCO <= 1'b0;
            O_IRQ <= cfg.irq_en & ((xfer_done & (!cfg.cmp_en | cmp_hit)) | O_COCO);
        end
    end

    // Status mirrors.
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_ACTIVE  <= 1'b0;
            O_CHANNEL <= `ADCC_CH_IDLE;
        end else begin
            O_ACTIVE  <= (state != adcc_pkg::ST_IDLE);
            O_CHANNEL <= cfg.channel;
        end
    end

    a_idle_write_nostart: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (I_WR_SC1 && I_CFG.channel == `ADCC_CH_IDLE) |=> state == adcc_pkg::ST_IDLE)
        else $error("idle channel write started a conversion");
    a_sw_start_go: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        sw_start |=> state == adcc_pkg::ST_START)
        else $error("software write did not start");
    a_busy_trig_drop: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (state == adcc_pkg::ST_CONV && !I_WR_SC1) |=> state != adcc_pkg::ST_START)
        else $error("conversion restarted mid-algorithm");
    a_hw_start_go: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (hw_start && !I_WR_SC1) |=> state == adcc_pkg::ST_START)
        else $error("trigger edge did not start");
    a_cont_no_hw: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (cont_run && !I_WR_SC1) |=> cont_run && !first)
        else $error("trigger relaunched a continuous run");
    a_single_idle: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (xfer_done && !cfg.cont) |=> state == adcc_pkg::ST_IDLE)
        else $error("single conversion did not return idle");
    a_cont_restart: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (xfer_done && cfg.cont) |=> state == adcc_pkg::ST_START)
        else $error("continuous run did not restart");
    a_result_load: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (xfer_done && !cfg.cmp_en) |=> O_RESULT_LOW == $past(res[7:0]) && O_COCO)
        else $error("result not loaded on completion");
    a_pin_takeover: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        ##1 ((O_PIN_OE | O_PIN_PU) & $past(I_PIN_DIS)) == '0)
        else $error("disabled pin still driven or pulled up");
    a_port_read_zero: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        ##1 (O_PORT_RD & $past(I_PIN_DIS)) == '0)
        else $error("disabled pin still read");
    a_abort_run: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        I_WR_SC1 |=> !cont_run)
        else $error("continuous run survived a control write");
    a_cmp_miss_hold: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (xfer_done && cfg.cmp_en && !cmp_hit && !O_COCO) |=> !O_COCO && $stable(O_RESULT_LOW))
        else $error("compare miss loaded or flagged");
    a_irq_raise: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (cfg.irq_en && O_COCO) |=> O_IRQ)
        else $error("enabled completion raised no interrupt");
    a_bit_on_tick: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (state == adcc_pkg::ST_CONV && !tick && !I_WR_SC1) |=> $stable(bitpos))
        else $error("bit decided without a conversion clock");
endmodule : adcc_top

/* verif/adcc_analog_model.sv */
`timescale 1ns/1ps
// Far side of the converter: analog pin level, comparator and the slower clock sources.
module adcc_analog_model (
    input  wire logic       i_clk,      // Bus clock.
    input  wire logic       i_arst_n,   // Reset, active low.
    input  wire logic       i_trial,    // Bit decision in progress.
    input  wire logic [9:0] i_sar,      // Trial code on the converter.
    input  wire logic [9:0] i_level,    // Pin level expressed as a code.
    output logic            o_cmp,      // Comparator decision.
    output logic            o_alt_en,   // Alternate source enable pulse.
    output logic            o_async_en  // Asynchronous source enable pulse.
);
    logic [1:0] phase;
    logic       flip;

    // Both sources run slower than the bus, so sample timing stays exact.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            phase <= 2'h0;
            flip  <= 1'h0;
        end else begin
            phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
            flip  <= ~flip;
        end
    end

    // One pulse in three cycles and one in two.
    assign o_alt_en   = (phase == 2'h0);
    assign o_async_en = flip;
    // Outside a decision the output toggles, so a stale level cannot pass for an answer.
    assign o_cmp = i_trial ? (i_level >= i_sar) : flip;
endmodule : adcc_analog_model

/* verif/adcc_top_bench.sv */
`timescale 1ns/1ps
`include "adcc_map.svh"
// Self-checking bench: control writes, pin takeover and trigger sequences.
module adcc_top_bench;
    localparam int PINS      = 8;
    localparam int START_CYC = 4;
    logic                clk, arst_n, wr, clr, trig, cmp, alt_en, async_en, trial, active;
    logic                coco, irq;
    adcc_pkg::adcc_cfg_s cfg;
    logic [PINS-1:0]     dis, oe, pu, pin_in, pin_oe, pin_pu, port_rd;
    logic [4:0]          chan;
    logic [9:0]          sar, level;
    logic [7:0]          res_hi, res_lo;
    int                  n_errors, n_compared, cnt, pd, extra;

    adcc_top #(.PINS(PINS), .START_CYC(START_CYC)) u_adcc_top (
        .I_CLK(clk), .I_ARST_N(arst_n), .I_WR_SC1(wr), .I_CFG(cfg), .I_CLR_COCO(clr),
        .I_HW_TRIG(trig), .I_ALT_EN(alt_en), .I_ASYNC_EN(async_en), .I_CMP_OUT(cmp),
        .I_PIN_DIS(dis), .I_PORT_OE(oe), .I_PORT_PU(pu), .I_PIN_IN(pin_in),
        .O_PIN_OE(pin_oe), .O_PIN_PU(pin_pu), .O_PORT_RD(port_rd), .O_CHANNEL(chan),
        .O_TRIAL(trial), .O_SAR(sar), .O_ACTIVE(active), .O_RESULT_HIGH(res_hi),
        .O_RESULT_LOW(res_lo), .O_COCO(coco), .O_IRQ(irq));

    adcc_analog_model u_adcc_analog_model (
        .i_clk(clk), .i_arst_n(arst_n), .i_trial(trial), .i_sar(sar), .i_level(level),
        .o_cmp(cmp), .o_alt_en(alt_en), .o_async_en(async_en));

    // Bus clock at 100 MHz.
    always #5 clk = ~clk;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic conclude();
        if (n_errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    // Control write, held across exactly one sampling edge.
    task automatic write_ctl();
        @(negedge clk);
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : write_ctl

    // Bounded wait for the complete flag; cnt counts bus cycles spent.
    task automatic wait_done();
        cnt = 0;
        while (coco !== 1'b1) begin
            @(negedge clk);
            cnt++;
            if (cnt > 3000) begin
                check("done_timeout", 32'h0, 32'h1);
                conclude();
            end
        end
    endtask : wait_done

    // The converter must stay idle; the first two cycles let a finished run settle.
    task automatic quiet(input int n);
        repeat (2) @(negedge clk);
        repeat (n) begin
            @(negedge clk);
            check("idle", 32'(active), 32'h0);
        end
    endtask : quiet

    task automatic conv(input int lo, input int hi, input logic [9:0] exp);
        write_ctl();
        wait_done();
        check("time_min", 32'(cnt >= lo), 32'h1);
        check("time_max", 32'(cnt <= hi), 32'h1);
        check("result", {res_hi, res_lo}, 32'(exp));
    endtask : conv

    // Main sequence.
    initial begin
        clk = 1'b0; arst_n = 1'b0; wr = 1'b0; clr = 1'b0; trig = 1'b0;
        cfg = '0;
        level = 10'h2a5; dis = 8'h5a; oe = 8'hff; pu = 8'hff; pin_in = 8'hff;
        n_errors = 0;
        n_compared = 0;
        repeat (16) @(negedge clk);
        check("reset_channel", 32'(chan), 32'h1f);
        check("reset_flags", {active, coco, irq}, 32'h0);
        arst_n = 1'b1;
        repeat (3) @(negedge clk);
        check("pin_oe", pin_oe, 32'ha5);
        check("pin_pu", pin_pu, 32'ha5);
        check("port_rd", port_rd, 32'ha5);
        // Every source and divide ratio; the async source adds its start-up time.
        cfg.mode = `ADCC_MODE_10BIT;
        for (int s = 0; s < 4; s++) begin
            for (int d = 0; d < 4; d++) begin
                cfg.iclk = 2'(s);
                cfg.div = 2'(d);
                pd = (s == 2 ? 3 : (s == 0 ? 1 : 2)) << d;
                extra = (s == 3) ? START_CYC : 0;
                conv(15 * pd + extra, 24 * pd + 8 + extra, 10'h2a5);
            end
        end
        // Eight bits, long sample, then back to idle.
        level = 10'h3ff;
        cfg.iclk = 2'h0; cfg.div = 2'h0; cfg.mode = `ADCC_MODE_8BIT; cfg.long_smp = 1'b1;
        conv(33, 48, 10'h0ff);
        quiet(20);
        // Continuous run, then an abort by an idle-channel write.
        level = 10'h2a5;
        cfg.mode = `ADCC_MODE_10BIT; cfg.long_smp = 1'b0; cfg.cont = 1'b1;
        conv(15, 31, 10'h2a5);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        wait_done();
        check("cont_max", 32'(cnt <= 23), 32'h1);
        check("cont_min", 32'(cnt >= 12), 32'h1);
        cfg.channel = `ADCC_CH_IDLE;
        write_ctl();
        quiet(30);
        check("abort_flag", 32'(coco), 32'h0);
        // Hardware trigger: a write starts nothing, an edge while busy is ignored.
        cfg.channel = 5'h00; cfg.cont = 1'b0; cfg.hw_trig = 1'b1;
        write_ctl();
        quiet(20);
        trig = 1'b1;
        repeat (6) @(negedge clk);
        trig = 1'b0;
        repeat (3) @(negedge clk);
        check("hw_started", 32'(active), 32'h1);
        trig = 1'b1;
        wait_done();
        check("hw_result", {res_hi, res_lo}, 32'h02a5);
        quiet(60);
        trig = 1'b0;
        // Continuous hardware run: one edge launches it, a later edge changes nothing.
        cfg.cont = 1'b1;
        write_ctl();
        quiet(10);
        trig = 1'b1;
        wait_done();
        check("hw_cont_result", {res_hi, res_lo}, 32'h02a5);
        trig = 1'b0;
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        repeat (3) @(negedge clk);
        trig = 1'b1;
        wait_done();
        check("hw_cont_time", 32'(cnt <= 20), 32'h1);
        check("hw_cont_busy", 32'(active), 32'h1);
        trig = 1'b0;
        // Compare: a miss flags nothing, a hit flags and interrupts.
        cfg.cont = 1'b0;
        cfg.hw_trig = 1'b0; cfg.cmp_en = 1'b1; cfg.cmp_gte = 1'b1;
        cfg.cmp_val = 10'h300; cfg.irq_en = 1'b1;
        write_ctl();
        repeat (60) @(negedge clk);
        check("cmp_miss", {active, coco, irq}, 32'h0);
        cfg.cmp_gte = 1'b0;
        conv(15, 31, 10'h2a5);
        @(negedge clk);
        check("irq_set", 32'(irq), 32'h1);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        @(negedge clk);
        check("irq_clear", {coco, irq}, 32'h0);
        conclude();
    end
endmodule : adcc_top_bench
